// ---- common/charge_ctl_pkg.sv ----
// constants and types for the charge mode controller
// Behaviour
// - leave reset only after supply stays above start threshold for one second
// - after start-up, re-enter reset only on supply undervoltage
// - pass-gate drive held low while in reset
// - boost input high enters boost from standby, or outside reset and fault if battery not low; current setpoint raised to boost level
// - charge pause overrides boost
// - charge pause halts charging at once; released pause resumes the cycle
// - enable rising starts charging sequence from standby
// - standby releases both indicators
// - conditioning below low-battery threshold under one hour: A low, B released
// - still low battery after one hour: defective pack, A blinks
// - fast charge: A low, B released
// - low sense current with low resistance-free voltage: defective, A blinks
// - top-off and monitor: A released, B low
// - boost drives both indicators low
// - battery overvoltage or sense overcurrent: fault, both indicators blink
// - enable low leaves fault for standby
// - top-off lasts one hour, then gate off and monitor
package charge_ctl_pkg;
  typedef enum logic [3:0] {
    ST_RESET, ST_STANDBY, ST_QUALIFY, ST_COND, ST_FAST, ST_SETTLE,
    ST_TOPOFF, ST_MONITOR, ST_DEFECT, ST_FAULT, ST_BOOST
  } mode_t;
  typedef enum logic [1:0] {
    SP_OFF, SP_COND, SP_FAST, SP_BOOST
  } setpoint_t;
  localparam int CLK_HZ        = 200_000_000;
  localparam int SECOND_S      = 1;
  localparam int TICKS_PER_SEC = CLK_HZ * SECOND_S;
  localparam int HOUR_S        = 3600;
  localparam int BLINK_MS      = 625;   // half period of 0.8 Hz
  localparam int BLINK_TICKS   = CLK_HZ / 1000 * BLINK_MS;
endpackage

// ---- rtl/time_base.sv ----
// time base counter chain: second ticks, hour ticks, blink
`timescale 1ns/1ps
module time_base #(
  parameter int SEC_CYCLES   = charge_ctl_pkg::TICKS_PER_SEC,
  parameter int BLINK_CYCLES = charge_ctl_pkg::BLINK_TICKS,
  parameter int HOUR_SECS    = charge_ctl_pkg::HOUR_S
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic restart,
  output logic      sec_tick,
  output logic      hour_tick,
  output logic      blink
);
  logic [31:0] sec_cnt_q;
  logic [31:0] blink_cnt_q;
  logic [15:0] hour_cnt_q;
  wire sec_end   = (sec_cnt_q == 32'(SEC_CYCLES - 1));
  wire blink_end = (blink_cnt_q == 32'(BLINK_CYCLES - 1));
  wire hour_end  = sec_end && (hour_cnt_q == 16'(HOUR_SECS - 1));

  // restartable second and hour chain; blink free-runs so it never stutters
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sec_cnt_q   <= 32'h0;
      hour_cnt_q  <= 16'h0;
      blink_cnt_q <= 32'h0;
      sec_tick    <= 1'b0;
      hour_tick   <= 1'b0;
      blink       <= 1'b0;
    end else begin
      sec_tick    <= sec_end && !restart;
      hour_tick   <= hour_end && !restart;
      blink_cnt_q <= blink_end ? 32'h0 : blink_cnt_q + 32'h1;
      if (blink_end) begin
        blink <= !blink;
      end
      if (restart || sec_end) begin
        sec_cnt_q <= 32'h0;
      end else begin
        sec_cnt_q <= sec_cnt_q + 32'h1;
      end
      if (restart || hour_end) begin
        hour_cnt_q <= 16'h0;
      end else if (sec_end) begin
        hour_cnt_q <= hour_cnt_q + 16'h1;
      end
    end
  end
endmodule // time_base

// ---- rtl/charge_mode_ctl.sv ----
// charge mode controller: sequencing, gate drive and status indicators
`timescale 1ns/1ps
module charge_mode_ctl #(
  parameter int SEC_CYCLES   = charge_ctl_pkg::TICKS_PER_SEC,
  parameter int BLINK_CYCLES = charge_ctl_pkg::BLINK_TICKS,
  parameter int HOUR_SECS    = charge_ctl_pkg::HOUR_S
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        supply_above_start,
  input  wire logic        supply_undervolt,
  input  wire logic        enable,
  input  wire logic        boost,
  input  wire logic        charge_pause_n,
  input  wire logic        float_select,
  input  wire logic        batt_below_low,
  input  wire logic        batt_over,
  input  wire logic        sense_above_end,
  input  wire logic        sense_over,
  input  wire logic        rfv_low,
  input  wire logic        batt_refresh,
  output logic             pass_gate_drive,
  output logic             status_indicator_a_oe,
  output logic             status_indicator_a_o,
  output logic             status_indicator_b_oe,
  output logic             status_indicator_b_o,
  output logic [1:0]       current_setpoint,
  output logic             float_select_q,
  output logic [3:0]       mode
);
  // input synchronisers: three stages, change taken when stages two and three agree
  localparam int NIN = 11;
  localparam logic [NIN-1:0] SYNC_RST = 11'h040; // pause pin idles high, so no false pause
  logic [NIN-1:0] s1_q;
  logic [NIN-1:0] s2_q;
  logic [NIN-1:0] s3_q;
  logic [NIN-1:0] in_q;
  wire  [NIN-1:0] raw_in = {supply_above_start, supply_undervolt, enable, boost,
                            charge_pause_n, float_select, batt_below_low, batt_over,
                            sense_above_end, sense_over, rfv_low};
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_sync
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          s1_q[gi] <= SYNC_RST[gi];
          s2_q[gi] <= SYNC_RST[gi];
          s3_q[gi] <= SYNC_RST[gi];
          in_q[gi] <= SYNC_RST[gi];
        end else begin
          s1_q[gi] <= raw_in[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi]) begin
            in_q[gi] <= s3_q[gi];
          end
        end
      end
    end
  endgenerate
  logic refr_s1_q;
  logic refr_s2_q;
  logic refr_s3_q;
  logic refr_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      refr_s1_q <= 1'b0;
      refr_s2_q <= 1'b0;
      refr_s3_q <= 1'b0;
      refr_q    <= 1'b0;
    end else begin
      refr_s1_q <= batt_refresh;
      refr_s2_q <= refr_s1_q;
      refr_s3_q <= refr_s2_q;
      if (refr_s2_q == refr_s3_q) begin
        refr_q <= refr_s3_q;
      end
    end
  end

  wire sup_ok   = in_q[10];
  wire sup_uv   = in_q[9];
  wire en       = in_q[8];
  wire bst      = in_q[7];
  wire pause    = !in_q[6];
  wire vsel     = in_q[5];
  wire low_bat  = in_q[4];
  wire over_v   = in_q[3];
  wire sns_hi   = in_q[2];
  wire over_i   = in_q[1];
  wire rfv_lo   = in_q[0];

  // mode state and edge tracking
  charge_ctl_pkg::mode_t state_q;
  charge_ctl_pkg::mode_t state_d;
  logic en_prev_q;
  logic sec_tick;
  logic hour_tick;
  logic blink;
  wire  en_rise  = en && !en_prev_q;
  wire  charging = (state_q == charge_ctl_pkg::ST_COND) || (state_q == charge_ctl_pkg::ST_FAST) ||
                   (state_q == charge_ctl_pkg::ST_TOPOFF);
  wire  fault_hit = en && (over_v || over_i);
  // timer restarts on every state change and while the supply is not yet good;
  // a pause in fast charge restarts it too, so end of charge is judged a full
  // second after current flows again
  wire  restart  = (state_d != state_q) ||
                   (state_q == charge_ctl_pkg::ST_RESET && (!sup_ok || sup_uv)) ||
                   (state_q == charge_ctl_pkg::ST_FAST && pause);

  time_base #(
    .SEC_CYCLES   (SEC_CYCLES),
    .BLINK_CYCLES (BLINK_CYCLES),
    .HOUR_SECS    (HOUR_SECS)
  ) u_time_base (
    .clk       (clk),
    .rst       (rst),
    .restart   (restart),
    .sec_tick  (sec_tick),
    .hour_tick (hour_tick),
    .blink     (blink)
  );

  // next mode; pause freezes fast charge and blocks boost, fault outranks both
  always_comb begin
    state_d  = state_q;
    case (state_q)
      charge_ctl_pkg::ST_RESET: begin
        if (sup_ok && !sup_uv && sec_tick) state_d = charge_ctl_pkg::ST_STANDBY;
      end
      charge_ctl_pkg::ST_STANDBY: begin
        if (bst && !pause) state_d = charge_ctl_pkg::ST_BOOST;
        else if (en_rise) state_d = charge_ctl_pkg::ST_QUALIFY;
      end
      charge_ctl_pkg::ST_QUALIFY: begin
        if (sec_tick) state_d = low_bat ? charge_ctl_pkg::ST_COND : charge_ctl_pkg::ST_FAST;
      end
      charge_ctl_pkg::ST_COND: begin
        if (!low_bat) state_d = charge_ctl_pkg::ST_FAST;
        else if (hour_tick) state_d = charge_ctl_pkg::ST_DEFECT;
      end
      charge_ctl_pkg::ST_FAST: begin
        // sense lags the gate through the synchroniser: judge it only on a second tick
        if (!sns_hi && sec_tick) state_d = charge_ctl_pkg::ST_SETTLE;
      end
      charge_ctl_pkg::ST_SETTLE: begin
        if (sec_tick) state_d = rfv_lo ? charge_ctl_pkg::ST_DEFECT : charge_ctl_pkg::ST_TOPOFF;
      end
      charge_ctl_pkg::ST_TOPOFF: begin
        if (hour_tick) state_d = charge_ctl_pkg::ST_MONITOR;
      end
      charge_ctl_pkg::ST_MONITOR: begin
        if (refr_q) state_d = charge_ctl_pkg::ST_FAST;
      end
      charge_ctl_pkg::ST_BOOST: begin
        if (!bst || pause) state_d = charge_ctl_pkg::ST_STANDBY;
      end
      default: state_d = state_q; // defect and fault wait for enable low
    endcase
    if (state_q != charge_ctl_pkg::ST_RESET && state_q != charge_ctl_pkg::ST_STANDBY
        && state_q != charge_ctl_pkg::ST_BOOST && !en) begin
      state_d = charge_ctl_pkg::ST_STANDBY;
    end else if (state_q != charge_ctl_pkg::ST_RESET && fault_hit) begin
      state_d = charge_ctl_pkg::ST_FAULT;
    end else if (state_q != charge_ctl_pkg::ST_RESET && state_q != charge_ctl_pkg::ST_STANDBY
                 && state_q != charge_ctl_pkg::ST_BOOST && state_q != charge_ctl_pkg::ST_FAULT
                 && bst && !pause && !low_bat) begin
      state_d  = charge_ctl_pkg::ST_BOOST;
    end
    if (state_q != charge_ctl_pkg::ST_RESET && sup_uv) state_d = charge_ctl_pkg::ST_RESET;
  end

  // outputs decoded from the next mode so every output is a flip-flop
  wire gate_on_d = !pause && ((state_d == charge_ctl_pkg::ST_COND) ||
                   (state_d == charge_ctl_pkg::ST_FAST) || (state_d == charge_ctl_pkg::ST_TOPOFF) ||
                   (state_d == charge_ctl_pkg::ST_BOOST));
  logic a_low_d;
  logic b_low_d;
  logic [1:0] sp_d;
  always_comb begin
    a_low_d = 1'b0;
    b_low_d = 1'b0;
    sp_d    = 2'(charge_ctl_pkg::SP_OFF);
    case (state_d)
      charge_ctl_pkg::ST_QUALIFY: a_low_d = 1'b1;
      charge_ctl_pkg::ST_COND: begin
        a_low_d = 1'b1;
        sp_d    = 2'(charge_ctl_pkg::SP_COND);
      end
      charge_ctl_pkg::ST_FAST, charge_ctl_pkg::ST_SETTLE: begin
        a_low_d = 1'b1;
        sp_d    = 2'(charge_ctl_pkg::SP_FAST);
      end
      charge_ctl_pkg::ST_TOPOFF, charge_ctl_pkg::ST_MONITOR: b_low_d = 1'b1;
      charge_ctl_pkg::ST_DEFECT: a_low_d = blink;
      charge_ctl_pkg::ST_FAULT: begin
        a_low_d = blink;
        b_low_d = blink;
      end
      charge_ctl_pkg::ST_BOOST: begin
        a_low_d = 1'b1;
        b_low_d = 1'b1;
        sp_d    = 2'(charge_ctl_pkg::SP_BOOST);
      end
      default: begin // reset and standby: released
        a_low_d = 1'b0;
        b_low_d = 1'b0;
      end
    endcase
  end

  // state, enable edge tracking and registered pins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q               <= charge_ctl_pkg::ST_RESET;
      status_indicator_a_o  <= 1'b0;
      status_indicator_b_o  <= 1'b0;
      en_prev_q             <= 1'b0;
      pass_gate_drive       <= 1'b0;
      status_indicator_a_oe <= 1'b0;
      status_indicator_b_oe <= 1'b0;
      current_setpoint      <= 2'h0;
      float_select_q        <= 1'b0;
      mode                  <= 4'h0;
    end else begin
      state_q               <= state_d;
      status_indicator_a_o  <= 1'b0; // drive level fixed low; the enable decides
      status_indicator_b_o  <= 1'b0;
      en_prev_q             <= en;
      pass_gate_drive       <= gate_on_d;
      status_indicator_a_oe <= a_low_d;
      status_indicator_b_oe <= b_low_d;
      current_setpoint      <= sp_d;
      float_select_q        <= vsel;
      mode                  <= 4'(state_d);
    end
  end

  // checks
  a_reset_gate_off: assert property (@(posedge clk) disable iff (rst)
    state_q == charge_ctl_pkg::ST_RESET |-> !pass_gate_drive) else $error("gate on in reset");
  a_pause_gate_off: assert property (@(posedge clk) disable iff (rst)
    $past(pause) && $past(state_q) != charge_ctl_pkg::ST_RESET |-> !pass_gate_drive)
    else $error("gate on during pause");
  a_boost_leds_low: assert property (@(posedge clk) disable iff (rst)
    state_q == charge_ctl_pkg::ST_BOOST |-> status_indicator_a_oe && status_indicator_b_oe)
    else $error("boost indicators");
  a_boost_needs_run: assert property (@(posedge clk) disable iff (rst)
    $rose(state_q == charge_ctl_pkg::ST_BOOST) |-> $past(bst) && !$past(pause))
    else $error("boost entered under pause");
  a_standby_released: assert property (@(posedge clk) disable iff (rst)
    state_q == charge_ctl_pkg::ST_STANDBY |-> !status_indicator_a_oe && !status_indicator_b_oe)
    else $error("standby indicators");
  a_fault_entry: assert property (@(posedge clk) disable iff (rst)
    state_q != charge_ctl_pkg::ST_RESET && en && (over_v || over_i) && !sup_uv
    |=> state_q == charge_ctl_pkg::ST_FAULT) else $error("fault missed");
  a_fault_exit: assert property (@(posedge clk) disable iff (rst)
    state_q == charge_ctl_pkg::ST_FAULT && !en && !sup_uv
    |=> state_q == charge_ctl_pkg::ST_STANDBY) else $error("fault not left");
  a_topoff_ends: assert property (@(posedge clk) disable iff (rst)
    state_q == charge_ctl_pkg::ST_TOPOFF && state_d == charge_ctl_pkg::ST_MONITOR
    |=> !pass_gate_drive && status_indicator_b_oe) else $error("topoff end");
  a_uv_reset: assert property (@(posedge clk) disable iff (rst)
    sup_uv |=> state_q == charge_ctl_pkg::ST_RESET) else $error("undervoltage ignored");
  a_cond_leds: assert property (@(posedge clk) disable iff (rst)
    state_q == charge_ctl_pkg::ST_COND |-> status_indicator_a_oe && !status_indicator_b_oe)
    else $error("conditioning indicators");
  c_fast: cover property (@(posedge clk) state_q == charge_ctl_pkg::ST_FAST);
  c_monitor: cover property (@(posedge clk) state_q == charge_ctl_pkg::ST_MONITOR);
  c_fault: cover property (@(posedge clk) state_q == charge_ctl_pkg::ST_FAULT);
  c_boost: cover property (@(posedge clk) state_q == charge_ctl_pkg::ST_BOOST);
  c_defect: cover property (@(posedge clk) state_q == charge_ctl_pkg::ST_DEFECT);
endmodule // charge_mode_ctl

// ---- verification/pack_model.sv ----
// behavioural battery pack, power stage and indicator pull-ups
`timescale 1ns/1ps
module pack_model (
  input  wire logic pass_gate_drive,
  input  wire logic a_oe,
  input  wire logic a_o,
  input  wire logic b_oe,
  input  wire logic b_o,
  input  wire logic low_set,
  input  wire logic over_set,
  input  wire logic end_set,
  input  wire logic ocur_set,
  input  wire logic rfv_set,
  input  wire logic droop_set,
  output logic      batt_below_low,
  output logic      batt_over,
  output logic      sense_above_end,
  output logic      sense_over,
  output logic      rfv_low,
  output logic      batt_refresh,
  output logic      pin_a,
  output logic      pin_b
);
  // sense voltage exists only while the gate conducts; no current, no sense level
  assign sense_above_end = pass_gate_drive & end_set;
  assign sense_over      = pass_gate_drive & ocur_set;
  // pack levels, always driven to a defined value
  assign batt_below_low  = low_set;
  assign batt_over       = over_set;
  assign rfv_low         = rfv_set;
  assign batt_refresh    = droop_set;
  // released open-drain pins float up to the pull-up level
  assign pin_a = a_oe ? a_o : 1'b1;
  assign pin_b = b_oe ? b_o : 1'b1;
endmodule // pack_model

// ---- verification/liion_charge_mode_controller_tb.sv ----
// self-checking bench for the charge mode controller
`timescale 1ns/1ps
module liion_charge_mode_controller_tb;
  localparam int SEC = 20;
  localparam int HR  = 4;
  logic clk = 1'b0, rst = 1'b1, sup = 1'b0, uv = 1'b0, en = 1'b0, bst = 1'b0;
  logic pause_n = 1'b1, fsel = 1'b0, low_s = 1'b0, over_s = 1'b0, end_s = 1'b0;
  logic ocur_s = 1'b0, rfv_s = 1'b0, droop_s = 1'b0;
  logic bl, bo, se, so, rl, br, gate, a_oe, a_o, b_oe, b_o, fq, pin_a, pin_b;
  logic [1:0] sp;
  logic [3:0] mode;
  int err_count = 0, n_checks = 0;
  always #2.5 clk = ~clk;
  charge_mode_ctl #(.SEC_CYCLES(SEC), .BLINK_CYCLES(5), .HOUR_SECS(HR)) charge_mode_ctl_inst (
    .clk(clk), .rst(rst), .supply_above_start(sup), .supply_undervolt(uv), .enable(en),
    .boost(bst), .charge_pause_n(pause_n), .float_select(fsel), .batt_below_low(bl),
    .batt_over(bo), .sense_above_end(se), .sense_over(so), .rfv_low(rl), .batt_refresh(br),
    .pass_gate_drive(gate), .status_indicator_a_oe(a_oe), .status_indicator_a_o(a_o),
    .status_indicator_b_oe(b_oe), .status_indicator_b_o(b_o), .current_setpoint(sp),
    .float_select_q(fq), .mode(mode));
  pack_model pack_model_inst (
    .pass_gate_drive(gate), .a_oe(a_oe), .a_o(a_o), .b_oe(b_oe), .b_o(b_o), .low_set(low_s),
    .over_set(over_s), .end_set(end_s), .ocur_set(ocur_s), .rfv_set(rfv_s),
    .droop_set(droop_s), .batt_below_low(bl), .batt_over(bo), .sense_above_end(se),
    .sense_over(so), .rfv_low(rl), .batt_refresh(br), .pin_a(pin_a), .pin_b(pin_b));
  // inputs always change a fixed 1 ns after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // bounded wait for a mode; running out is a mismatch and ends the run
  task automatic wait_mode(input logic [3:0] m, input int bound);
    for (int i = 0; i < bound; i++) begin
      if (mode === m) return;
      step(1);
    end
    check(mode, m);
    stop_test();
  endtask
  // blinking pins must toggle at least twice over four blink periods
  task automatic blinks(input logic want_a, input logic want_b);
    int ta, tb;
    logic pa, pb;
    ta = 0;
    tb = 0;
    pa = pin_a;
    pb = pin_b;
    repeat (40) begin
      step(1);
      if (pin_a !== pa) ta++;
      if (pin_b !== pb) tb++;
      pa = pin_a;
      pb = pin_b;
    end
    check(ta >= 2, want_a);
    check(tb >= 2, want_b);
  endtask
  task automatic to_standby();
    en = 1'b0;
    wait_mode(charge_ctl_pkg::ST_STANDBY, 30);
    check({pin_a, pin_b}, 2'h3);
  endtask
  task automatic t_powerup();
    check({gate, a_oe, b_oe}, 3'h0);
    rst = 1'b0;
    sup = 1'b1;
    step(SEC / 2);
    check(mode, charge_ctl_pkg::ST_RESET);
    check(gate, 1'h0);
    wait_mode(charge_ctl_pkg::ST_STANDBY, SEC + 20);
    check({pin_a, pin_b}, 2'h3);
    fsel = 1'b1;
    step(8);
    check(fq, 1'h1);
    $display("test powerup done");
  endtask
  // conditioning: gate on, conditioning setpoint, A low, B released
  task automatic t_cond_defect();
    low_s = 1'b1;
    en = 1'b1;
    wait_mode(charge_ctl_pkg::ST_QUALIFY, 12);
    check(pin_a, 1'h0);
    wait_mode(charge_ctl_pkg::ST_COND, SEC + 12);
    step(2);
    check({gate, sp, pin_a, pin_b}, 5'h15);
    wait_mode(charge_ctl_pkg::ST_DEFECT, SEC * HR + 30);
    check(gate, 1'h0);
    blinks(1'b1, 1'b0);
    low_s = 1'b0;
    to_standby();
    $display("test conditioning done");
  endtask
  // fast charge: gate on, fast setpoint, A low, B released
  task automatic start_fast();
    end_s = 1'b1;
    en = 1'b1;
    wait_mode(charge_ctl_pkg::ST_FAST, SEC + 30);
    step(2);
    check({gate, sp, pin_a, pin_b}, 5'h19);
  endtask
  task automatic t_fast_topoff();
    start_fast();
    pause_n = 1'b0;
    bst = 1'b1;
    step(8);
    check(gate, 1'h0);
    check(mode, charge_ctl_pkg::ST_FAST);
    bst = 1'b0;
    pause_n = 1'b1;
    step(8);
    check({gate, mode}, {1'b1, charge_ctl_pkg::ST_FAST});
    end_s = 1'b0;
    wait_mode(charge_ctl_pkg::ST_TOPOFF, 2 * SEC + 30);
    step(2);
    check({gate, pin_a, pin_b}, 3'h6);
    wait_mode(charge_ctl_pkg::ST_MONITOR, SEC * HR + 30);
    step(2);
    check({gate, pin_a, pin_b}, 3'h2);
    end_s = 1'b1;
    droop_s = 1'b1;
    wait_mode(charge_ctl_pkg::ST_FAST, 20);
    droop_s = 1'b0;
    to_standby();
    $display("test fast and top-off done");
  endtask
  task automatic t_rfv_defect();
    start_fast();
    rfv_s = 1'b1;
    end_s = 1'b0;
    wait_mode(charge_ctl_pkg::ST_DEFECT, 2 * SEC + 30);
    check(gate, 1'h0);
    blinks(1'b1, 1'b0);
    rfv_s = 1'b0;
    to_standby();
    $display("test high resistance done");
  endtask
  task automatic t_fault();
    start_fast();
    ocur_s = 1'b1;
    wait_mode(charge_ctl_pkg::ST_FAULT, 20);
    ocur_s = 1'b0;
    to_standby();
    over_s = 1'b1;
    en = 1'b1;
    wait_mode(charge_ctl_pkg::ST_FAULT, SEC + 30);
    check(gate, 1'h0);
    blinks(1'b1, 1'b1);
    over_s = 1'b0;
    to_standby();
    $display("test fault done");
  endtask
  // boost, then a brown-out and a fresh one-second start-up
  task automatic t_boost_uv();
    bst = 1'b1;
    wait_mode(charge_ctl_pkg::ST_BOOST, 20);
    step(2);
    check({sp, pin_a, pin_b}, 4'hC);
    blinks(1'b0, 1'b0);
    bst = 1'b0;
    wait_mode(charge_ctl_pkg::ST_STANDBY, 20);
    start_fast();
    uv = 1'b1;
    wait_mode(charge_ctl_pkg::ST_RESET, 12);
    check(gate, 1'h0);
    step(2 * SEC);
    check(mode, charge_ctl_pkg::ST_RESET);
    uv = 1'b0;
    step(SEC / 2);
    check({gate, mode}, {1'b0, charge_ctl_pkg::ST_RESET});
    wait_mode(charge_ctl_pkg::ST_STANDBY, SEC + 20);
    $display("test boost and undervoltage done");
  endtask
  initial begin
    step(20);
    t_powerup();
    t_cond_defect();
    t_fast_topoff();
    t_rfv_defect();
    t_fault();
    t_boost_uv();
    stop_test();
  end
endmodule // liion_charge_mode_controller_tb
